//--- hw/umcl_err_count.sv
// Purpose: Counts errored characters held in the receive FIFO
// Assumes: Push, pop and flush strobes come from the FIFO controller
// Notes: Flag is registered and follows the count

`timescale 1ns/1ps

module umcl_err_count #(
  parameter int DEPTH = umcl_pkg::RX_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // FIFO events
  input wire logic push,
  input wire logic push_err,
  input wire logic pop,
  input wire logic pop_err,
  input wire logic flush,
  // Summary
  output logic err_any
);
  import umcl_pkg::*;

  localparam int CW = $clog2(DEPTH + 1);

  generate
    if (DEPTH < 1)
    begin : g_bad
      $error("umcl_err_count: DEPTH must be at least 1");
    end
  endgenerate

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic err_ff;
  logic nxt_err;
  logic inc;
  logic dec;

  // ---------------------------------------------------------------
  // Count update
  // ---------------------------------------------------------------
  // Simultaneous errored push and pop cancel unless the count is zero, so no event is lost
  always_comb
  begin
    inc = push & push_err;
    dec = pop & pop_err & (cnt_ff != '0);
    nxt_cnt = cnt_ff;
    if (flush)
      nxt_cnt = '0;
    else if (inc && !dec && cnt_ff != CW'(DEPTH))
      nxt_cnt = cnt_ff + CW'(1);
    else if (dec && !inc)
      nxt_cnt = cnt_ff - CW'(1);
    nxt_err = (nxt_cnt != '0);
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cnt_ff <= '0;
      err_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      err_ff <= nxt_err;
    end
  end

  assign err_any = err_ff;

  err_flag_a: assert property (@(posedge clk) disable iff (reset)
    err_any == (cnt_ff != '0))
    else $error("error flag disagrees with count");

  err_clear_a: assert property (@(posedge clk) disable iff (reset)
    (cnt_ff == CW'(1) && pop && pop_err && !(push && push_err)) |=> !err_any)
    else $error("error flag not cleared after last errored pop");

  err_set_a: assert property (@(posedge clk) disable iff (reset)
    (push && push_err && !flush) |=> err_any)
    else $error("error flag not set after errored push");

endmodule

//--- hw/umcl_top.sv
// Purpose: Modem control register, loopback routing, line status bits 7:6
// Assumes: All pin inputs synchronous to clk; FIFO logic reports events
// Notes: Modem control bits 7:5 are outside this block and read as zero
//
// Added by the designer: the register offsets and the strobed register port.

`timescale 1ns/1ps

module umcl_top #(
  parameter int RX_DEPTH = umcl_pkg::RX_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [umcl_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [umcl_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [umcl_pkg::DATA_W-1:0] reg_rdata,
  // Transmitter status
  input wire logic fifo_en,
  input wire logic holding_empty,
  input wire logic tx_fifo_empty,
  input wire logic shift_empty,
  // Receive FIFO events
  input wire logic rx_push,
  input wire logic rx_push_err,
  input wire logic rx_pop,
  input wire logic rx_pop_err,
  input wire logic rx_flush,
  // Remaining line status bits
  input wire logic [umcl_pkg::LS_LOW_W-1:0] ls_low,
  // Serial data
  input wire logic tx_serial,
  output logic rx_serial,
  output logic tx_pin,
  input wire logic rx_pin,
  // Modem pins
  input wire logic cts_n_pin,
  input wire logic dsr_n_pin,
  input wire logic carrier_detect_in_n,
  input wire logic ring_indicator_in_n,
  output logic rts_n,
  output logic dtr_n,
  // Modem state toward status logic
  output logic [umcl_pkg::MS_W-1:0] modem_state,
  output logic [umcl_pkg::MS_W-1:0] modem_delta,
  output logic loopback_on
);
  import umcl_pkg::*;

  generate
    if (RX_DEPTH < 1)
    begin : g_bad
      $error("umcl_top: RX_DEPTH must be at least 1");
    end
  endgenerate

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] r);
    hit = (a == r);
  endfunction

  // ---------------------------------------------------------------
  // Modem control register
  // ---------------------------------------------------------------
  logic [MC_W-1:0] mc_ff;
  logic [MC_W-1:0] nxt_mc;
  logic loop_sel;

  always_comb
  begin
    nxt_mc = mc_ff;
    if (reg_wr && hit(reg_addr, MODEM_CONTROL_ADDR))
      nxt_mc = reg_wdata[MC_W-1:0];
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      mc_ff <= MC_RESET;
    else
      mc_ff <= nxt_mc;
  end

  assign loop_sel = mc_ff[MC_LOOP];

  // ---------------------------------------------------------------
  // Pin and loopback routing
  // ---------------------------------------------------------------
  // Everything is registered so outputs never glitch on a mode change
  logic tx_pin_ff;
  logic rx_ser_ff;
  logic rts_n_ff;
  logic dtr_n_ff;
  logic loop_ff;
  logic nxt_tx_pin;
  logic nxt_rx_ser;
  logic nxt_rts_n;
  logic nxt_dtr_n;

  always_comb
  begin
    nxt_rts_n = ~mc_ff[MC_RTS];
    nxt_dtr_n = ~mc_ff[MC_DTR];
    if (loop_sel)
    begin
      // Line held at idle mark while looped back
      nxt_tx_pin = 1'b1;
      nxt_rx_ser = tx_serial;
    end
    else
    begin
      nxt_tx_pin = tx_serial;
      nxt_rx_ser = rx_pin;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      tx_pin_ff <= 1'b1;
      rx_ser_ff <= 1'b1;
      rts_n_ff <= 1'b1;
      dtr_n_ff <= 1'b1;
      loop_ff <= 1'b0;
    end
    else
    begin
      tx_pin_ff <= nxt_tx_pin;
      rx_ser_ff <= nxt_rx_ser;
      rts_n_ff <= nxt_rts_n;
      dtr_n_ff <= nxt_dtr_n;
      loop_ff <= loop_sel;
    end
  end

  assign tx_pin = tx_pin_ff;
  assign rx_serial = rx_ser_ff;
  assign rts_n = rts_n_ff;
  assign dtr_n = dtr_n_ff;
  assign loopback_on = loop_ff;

  // ---------------------------------------------------------------
  // Modem state and change events
  // ---------------------------------------------------------------
  logic [MS_W-1:0] ms_ff;
  logic [MS_W-1:0] nxt_ms;
  logic [MS_W-1:0] delta_ff;
  logic [MS_W-1:0] nxt_delta;

  always_comb
  begin
    if (loop_sel)
    begin
      nxt_ms[MS_CTS] = mc_ff[MC_RTS];
      nxt_ms[MS_DSR] = mc_ff[MC_DTR];
      nxt_ms[MS_RING] = mc_ff[MC_RING_FB];
      nxt_ms[MS_CARRIER] = mc_ff[MC_CARRIER_FB];
    end
    else
    begin
      // Feedback bits are ignored outside loopback
      nxt_ms[MS_CTS] = ~cts_n_pin;
      nxt_ms[MS_DSR] = ~dsr_n_pin;
      nxt_ms[MS_RING] = ~ring_indicator_in_n;
      nxt_ms[MS_CARRIER] = ~carrier_detect_in_n;
    end
    nxt_delta = nxt_ms ^ ms_ff;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ms_ff <= '0;
      delta_ff <= '0;
    end
    else
    begin
      ms_ff <= nxt_ms;
      delta_ff <= nxt_delta;
    end
  end

  assign modem_state = ms_ff;
  assign modem_delta = delta_ff;

  // ---------------------------------------------------------------
  // Line status bits
  // ---------------------------------------------------------------
  logic fifo_err;
  logic temt_ff;
  logic nxt_temt;

  umcl_err_count #(
    .DEPTH(RX_DEPTH)
  ) u_err (
    .clk(clk),
    .reset(reset),
    .push(rx_push),
    .push_err(rx_push_err),
    .pop(rx_pop),
    .pop_err(rx_pop_err),
    .flush(rx_flush),
    .err_any(fifo_err)
  );

  always_comb
  begin
    if (fifo_en)
      nxt_temt = tx_fifo_empty & shift_empty;
    else
      nxt_temt = holding_empty & shift_empty;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      temt_ff <= 1'b1;
    else
      temt_ff <= nxt_temt;
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  // Read data is zero outside the answer cycle, easing bus muxing
  logic [DATA_W-1:0] rd_ff;
  logic [DATA_W-1:0] nxt_rd;

  always_comb
  begin
    nxt_rd = '0;
    if (reg_rd && hit(reg_addr, MODEM_CONTROL_ADDR))
      nxt_rd = {{(DATA_W-MC_W){1'b0}}, mc_ff};
    else if (reg_rd && hit(reg_addr, LINE_STATUS_ADDR))
      nxt_rd = {fifo_err, temt_ff, ls_low};
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      rd_ff <= '0;
    else
      rd_ff <= nxt_rd;
  end

  assign reg_rdata = rd_ff;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  loop_data_a: assert property (@(posedge clk) disable iff (reset)
    loop_sel |=> (rx_serial == $past(tx_serial) && tx_pin))
    else $error("loopback data not routed");

  rts_pin_a: assert property (@(posedge clk) disable iff (reset)
    (reg_wr && reg_addr == MODEM_CONTROL_ADDR)
    |=> ##1 (rts_n == !$past(reg_wdata[MC_RTS], 2)))
    else $error("rts pin does not follow control bit");

  dtr_pin_a: assert property (@(posedge clk) disable iff (reset)
    (reg_wr && reg_addr == MODEM_CONTROL_ADDR)
    |=> ##1 (dtr_n == !$past(reg_wdata[MC_DTR], 2)))
    else $error("dtr pin does not follow control bit");

  loop_enter_a: assert property (@(posedge clk) disable iff (reset)
    (reg_wr && reg_addr == MODEM_CONTROL_ADDR)
    |=> ##1 (loopback_on == $past(reg_wdata[MC_LOOP], 2)))
    else $error("loopback mode does not follow control bit");

  fb_bits_a: assert property (@(posedge clk) disable iff (reset)
    loop_sel |=> (modem_state[MS_CARRIER] == $past(mc_ff[MC_CARRIER_FB])
                  && modem_state[MS_RING] == $past(mc_ff[MC_RING_FB])))
    else $error("feedback bits not driving modem state");

  pins_norm_a: assert property (@(posedge clk) disable iff (reset)
    !loop_sel |=> (modem_state[MS_CARRIER] == !$past(carrier_detect_in_n)
                   && modem_state[MS_RING] == !$past(ring_indicator_in_n)))
    else $error("modem state not from pins in normal mode");

  ms_delta_a: assert property (@(posedge clk) disable iff (reset)
    $past(!reset) |-> modem_delta == (modem_state ^ $past(modem_state)))
    else $error("modem change event mismatch");

  temt_a: assert property (@(posedge clk) disable iff (reset)
    ##1 temt_ff == ($past(fifo_en) ? $past(tx_fifo_empty & shift_empty)
                                   : $past(holding_empty & shift_empty)))
    else $error("transmitter empty flag wrong");

  temt_busy_a: assert property (@(posedge clk) disable iff (reset)
    (!shift_empty) |=> !temt_ff)
    else $error("transmitter empty while shifting");

  mc_read_a: assert property (@(posedge clk) disable iff (reset)
    (reg_rd && reg_addr == MODEM_CONTROL_ADDR)
    |=> reg_rdata == {3'h0, $past(mc_ff)})
    else $error("modem control readback wrong");

  ls_read_a: assert property (@(posedge clk) disable iff (reset)
    (reg_rd && reg_addr == LINE_STATUS_ADDR)
    |=> reg_rdata[LS_FIFO_ERR] == $past(fifo_err))
    else $error("fifo error bit readback wrong");

  loop_cov_c: cover property (@(posedge clk) disable iff (reset)
    !loopback_on ##1 loopback_on);
  rts_cov_c: cover property (@(posedge clk) disable iff (reset)
    rts_n ##1 !rts_n);
  ferr_cov_c: cover property (@(posedge clk) disable iff (reset)
    fifo_err ##1 !fifo_err);
  temt_cov_c: cover property (@(posedge clk) disable iff (reset)
    fifo_en && !temt_ff ##1 temt_ff);

endmodule

//--- inc/umcl_pkg.sv
// Purpose: Shared constants for the modem control and line status block
// Assumes: 8-bit register port, 3-bit register address
// Notes: Register addresses are local to this block's decoder

package umcl_pkg;

  // ---------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] MODEM_CONTROL_ADDR = 3'h4;
  localparam logic [ADDR_W-1:0] LINE_STATUS_ADDR = 3'h5;

  // ---------------------------------------------------------------
  // Modem control fields
  // ---------------------------------------------------------------
  localparam int MC_W = 5;
  localparam int MC_LOOP = 4;
  localparam int MC_CARRIER_FB = 3;
  localparam int MC_RING_FB = 2;
  localparam int MC_RTS = 1;
  localparam int MC_DTR = 0;
  localparam logic [MC_W-1:0] MC_RESET = 5'h00;

  // ---------------------------------------------------------------
  // Line status fields
  // ---------------------------------------------------------------
  localparam int LS_FIFO_ERR = 7;
  localparam int LS_TX_EMPTY = 6;
  localparam int LS_LOW_W = 6;

  // ---------------------------------------------------------------
  // Modem state order: cts, dsr, ring, carrier
  // ---------------------------------------------------------------
  localparam int MS_W = 4;
  localparam int MS_CTS = 0;
  localparam int MS_DSR = 1;
  localparam int MS_RING = 2;
  localparam int MS_CARRIER = 3;

  // ---------------------------------------------------------------
  // Receive FIFO
  // ---------------------------------------------------------------
  localparam int RX_FIFO_DEPTH = 128;

endpackage

//--- verification/tb_top.sv
// Purpose: Register, loopback and status tests
// Assumes: Small error depth for saturation case
// Notes: Modem events summed over a few cycles

`timescale 1ns/1ps

module tb_top;
  import umcl_pkg::*;
  logic clk = 0;
  logic reset = 1;
  logic [ADDR_W-1:0] reg_addr = 0;
  logic [DATA_W-1:0] reg_wdata = 0;
  logic [DATA_W-1:0] reg_rdata;
  logic [DATA_W-1:0] rd;
  logic [DATA_W-1:0] ex;
  logic reg_wr = 0, reg_rd = 0, fifo_en = 0, holding_empty = 1, tx_fifo_empty = 1, shift_empty = 1;
  logic rx_push = 0, rx_push_err = 0, rx_pop = 0, rx_pop_err = 0, rx_flush = 0;
  logic [LS_LOW_W-1:0] ls_low = 0;
  logic tx_serial = 1, carrier_lvl = 1, ring_lvl = 1, line_lvl = 1;
  logic rx_serial, tx_pin, rx_pin, cts_n_pin, dsr_n_pin, rts_n, dtr_n, loopback_on;
  logic carrier_detect_in_n, ring_indicator_in_n;
  logic [MS_W-1:0] modem_state, modem_delta, acc, prev;
  logic [MS_W-1:0] mapv [4] = '{4'h2, 4'h1, 4'h4, 4'h8};
  int err_total = 0;
  int n_checks = 0;

  umcl_top #(.RX_DEPTH(4)) u_umcl_top (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fifo_en(fifo_en), .holding_empty(holding_empty), .tx_fifo_empty(tx_fifo_empty),
    .shift_empty(shift_empty),
    .rx_push(rx_push), .rx_push_err(rx_push_err), .rx_pop(rx_pop), .rx_pop_err(rx_pop_err),
    .rx_flush(rx_flush), .ls_low(ls_low), .tx_serial(tx_serial), .rx_serial(rx_serial),
    .tx_pin(tx_pin), .rx_pin(rx_pin), .cts_n_pin(cts_n_pin), .dsr_n_pin(dsr_n_pin),
    .carrier_detect_in_n(carrier_detect_in_n), .ring_indicator_in_n(ring_indicator_in_n),
    .rts_n(rts_n), .dtr_n(dtr_n), .modem_state(modem_state), .modem_delta(modem_delta),
    .loopback_on(loopback_on));

  umcl_modem_model u_umcl_modem_model (.rts_n(rts_n), .dtr_n(dtr_n), .carrier_lvl(carrier_lvl),
    .ring_lvl(ring_lvl), .line_lvl(line_lvl), .cts_n_pin(cts_n_pin), .dsr_n_pin(dsr_n_pin),
    .carrier_detect_in_n(carrier_detect_in_n), .ring_indicator_in_n(ring_indicator_in_n),
    .rx_pin(rx_pin));

  // ---------------------------------------------------------------
  // Bus and compare tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rdr(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask

  // Sums event pulses so their exact cycle does not matter
  task automatic settle();
    acc = 0;
    repeat (4)
    begin
      @(posedge clk);
      #1 acc = acc | modem_delta;
    end
  endtask

  task automatic ev(input logic [4:0] e);
    @(posedge clk);
    {rx_push, rx_push_err, rx_pop, rx_pop_err, rx_flush} <= e;
    @(posedge clk);
    {rx_push, rx_push_err, rx_pop, rx_pop_err, rx_flush} <= 5'h00;
  endtask

  task automatic errchk(input logic e);
    rdr(LINE_STATUS_ADDR);
    chk("fifo_err", 8'(e), 8'(rd[LS_FIFO_ERR]));
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    forever #2.5 clk = ~clk;
  end

  initial
  begin
    #100000;
    err_total++;
    close_out();
  end

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1 chk("rts_n", 8'h01, 8'(rts_n));
    chk("dtr_n", 8'h01, 8'(dtr_n));
    rdr(MODEM_CONTROL_ADDR);
    chk("mc_reset", 8'h00, rd);
    wr(LINE_STATUS_ADDR, 8'hFF);
    rdr(LINE_STATUS_ADDR);
    chk("ls_idle", 8'h40, rd);
    rdr(3'h7);
    chk("unmapped", 8'h00, rd);
    // Feedback bits set outside loopback must not reach state
    wr(MODEM_CONTROL_ADDR, 8'hEE);
    settle();
    chk("rts_on", 8'h00, 8'(rts_n));
    chk("dtr_off", 8'h01, 8'(dtr_n));
    chk("st_norm", 8'h01, 8'(modem_state));
    rdr(MODEM_CONTROL_ADDR);
    chk("mc_back", 8'h0E, rd);
    wr(MODEM_CONTROL_ADDR, 8'h01);
    @(posedge clk);
    tx_serial <= 1'b0;
    carrier_lvl <= 1'b0;
    ring_lvl <= 1'b0;
    settle();
    chk("dtr_on", 8'h00, 8'(dtr_n));
    chk("st_pins", 8'h0E, 8'(modem_state));
    chk("tx_pin", 8'h00, 8'(tx_pin));
    // Loopback isolates active pins
    wr(MODEM_CONTROL_ADDR, 8'h10);
    settle();
    chk("loop_on", 8'h01, 8'(loopback_on));
    chk("st_iso", 8'h00, 8'(modem_state));
    chk("tx_mark", 8'h01, 8'(tx_pin));
    chk("rx_loop", 8'h00, 8'(rx_serial));
    prev = 0;
    for (int i = 0; i < 4; i++)
    begin
      wr(MODEM_CONTROL_ADDR, 8'h10 | 8'(1 << i));
      settle();
      chk("st_loop", 8'(mapv[i]), 8'(modem_state));
      chk("delta", 8'(prev ^ mapv[i]), 8'(acc));
      rdr(MODEM_CONTROL_ADDR);
      chk("mc_loop", 8'h10 | 8'(1 << i), rd);
      prev = mapv[i];
    end
    wr(MODEM_CONTROL_ADDR, 8'h00);
    settle();
    chk("loop_off", 8'h00, 8'(loopback_on));
    chk("st_back", 8'h0C, 8'(modem_state));
    chk("rx_pin", 8'h01, 8'(rx_serial));
    // Transmitter empty over every source mix
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clk);
      {fifo_en, holding_empty, tx_fifo_empty, shift_empty} <= i[3:0];
      ls_low <= 6'(i * 3);
      rdr(LINE_STATUS_ADDR);
      ex = {1'b0, (i[3] ? i[1] : i[2]) & i[0], 6'(i * 3)};
      chk("ls_tx", ex, rd);
    end
    // Error count, underflow, cancel, saturation, flush
    ev(5'b11000);
    ev(5'b11000);
    ev(5'b10000);
    ev(5'b00110);
    errchk(1'b1);
    ev(5'b00110);
    errchk(1'b0);
    ev(5'b00110);
    ev(5'b11000);
    errchk(1'b1);
    ev(5'b11110);
    errchk(1'b1);
    ev(5'b00001);
    errchk(1'b0);
    repeat (6) ev(5'b11000);
    repeat (3) ev(5'b00110);
    errchk(1'b1);
    ev(5'b00110);
    errchk(1'b0);
    // Reset in mid-run clears control bits
    wr(MODEM_CONTROL_ADDR, 8'h1F);
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1 chk("loop_rst", 8'h00, 8'(loopback_on));
    chk("rts_rst", 8'h01, 8'(rts_n));
    rdr(MODEM_CONTROL_ADDR);
    chk("mc_rst", 8'h00, rd);
    close_out();
  end
endmodule

//--- verification/umcl_modem_model.sv
// Purpose: Far-side modem peer for the modem control block
// Assumes: Bench sets carrier, ring and line levels
// Notes: Echoes handshake requests back as grants

`timescale 1ns/1ps

module umcl_modem_model #(
  parameter int DLY = 1
) (
  // Pins from the block
  input wire logic rts_n,
  input wire logic dtr_n,
  // Bench levels
  input wire logic carrier_lvl,
  input wire logic ring_lvl,
  input wire logic line_lvl,
  // Pins toward the block
  output logic cts_n_pin,
  output logic dsr_n_pin,
  output logic carrier_detect_in_n,
  output logic ring_indicator_in_n,
  output logic rx_pin
);
  // Slow answer keeps grants off the sampling edge
  assign #(DLY) cts_n_pin = rts_n;
  assign #(DLY) dsr_n_pin = dtr_n;
  assign carrier_detect_in_n = carrier_lvl;
  assign ring_indicator_in_n = ring_lvl;
  assign rx_pin = line_lvl;
endmodule
